// ---- design/exec_pkg.sv ----
package exec_pkg;

  localparam int DATA_W = 8;
  localparam int ADDR_W = 7;
  localparam int PC_W = 13;
  localparam int STACK_DEPTH = 8;
  localparam int STACK_PTR_W = 3;

  // Operation select presented with each instruction; the binary opcode
  // encoding is decoded outside this block.
  typedef enum logic [2:0]
  {
    OP_NOP,
    OP_COPY_REGISTER,
    OP_LOAD_LITERAL,
    OP_STORE_ACCUMULATOR,
    OP_RETURN_WITH_LITERAL,
    OP_RETURN_FROM_INTERRUPT,
    OP_ROTATE_LEFT,
    OP_CALL
  } op_type;

  localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
  localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
  localparam logic TARGET_ACC = 1'h0;
  localparam logic TARGET_REG = 1'h1;
  localparam logic [STACK_PTR_W-1:0] PTR_RESET = 3'h0;

endpackage

// ---- design/return_stack_if.sv ----
`timescale 1ns/1ps
`default_nettype none

// Push and pop port of the hardware return stack
interface return_stack_if;
  logic push;
  logic pop;
  logic [exec_pkg::PC_W-1:0] push_addr;
  logic [exec_pkg::PC_W-1:0] top_of_stack;

  modport core
  (
    output push,
    output pop,
    output push_addr,
    input top_of_stack
  );

  modport stack
  (
    input push,
    input pop,
    input push_addr,
    output top_of_stack
  );
endinterface

`default_nettype wire

// ---- design/return_stack.sv ----
`timescale 1ns/1ps
`default_nettype none

module return_stack
(
  input wire logic mclk,
  input wire logic reset_n,
  return_stack_if.stack port_s
);

  logic [exec_pkg::PC_W-1:0] mem [exec_pkg::STACK_DEPTH];
  logic [exec_pkg::STACK_PTR_W-1:0] ptr;
  logic [exec_pkg::PC_W-1:0] top;

  // Circular: overflow silently overwrites the oldest entry
  wire [exec_pkg::STACK_PTR_W-1:0] ptr_up = ptr + 3'h1;
  wire [exec_pkg::STACK_PTR_W-1:0] ptr_down = ptr - 3'h1;

  always_ff @(posedge mclk)
  begin
    if (port_s.push)
      mem[ptr] <= port_s.push_addr;
  end

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ptr <= exec_pkg::PTR_RESET;
      top <= exec_pkg::PC_RESET;
    end
    else if (port_s.push)
    begin
      ptr <= ptr_up;
      top <= port_s.push_addr;
    end
    else if (port_s.pop)
    begin
      ptr <= ptr_down;
      top <= mem[ptr_down - 3'h1];
    end
  end

  assign port_s.top_of_stack = top;

endmodule // return_stack

`default_nettype wire

// ---- design/move_return_rotate_exec.sv ----
// What this block does
// - Copy register to accumulator or itself
// - Copy updates result_null_flag from value
// - Load literal to accumulator, flags kept
// - Store accumulator to register, flags kept
// - Return_with_literal loads literal, flags kept
// - Return_with_literal pops stack into PC
// - Return_with_literal takes two cycles
// - Rotate left through carry, carry only
// - Rotate result to accumulator or register
`timescale 1ns/1ps
`default_nettype none

module move_return_rotate_exec
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire exec_pkg::op_type instr_op,
  input wire logic [exec_pkg::ADDR_W-1:0] operand_register_index,
  input wire logic result_target_select,
  input wire logic [exec_pkg::DATA_W-1:0] literal_value,
  input wire logic [exec_pkg::PC_W-1:0] call_target,
  input wire logic [exec_pkg::DATA_W-1:0] reg_rdata,
  output logic [exec_pkg::ADDR_W-1:0] reg_addr,
  output logic reg_we,
  output logic [exec_pkg::DATA_W-1:0] reg_wdata,
  output logic [exec_pkg::PC_W-1:0] program_counter,
  output logic [exec_pkg::DATA_W-1:0] accumulator,
  output logic result_null_flag,
  output logic rotate_out_bit,
  output logic master_interrupt_enable,
  output logic flush,
  output logic instr_ready
);

  ////////////////////////////////////////////////////////////////////////
  // Reset release

  // The pin is asynchronous to mclk: assert at once, release through
  // two flops so that no register leaves reset on a marginal edge
  logic reset_sync;
  logic core_reset_n;

  always_ff @(posedge mclk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reset_sync <= 1'h0;
      core_reset_n <= 1'h0;
    end
    else
    begin
      reset_sync <= 1'h1;
      core_reset_n <= reset_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Decode

  typedef enum logic
  {
    EXEC_RUN,
    EXEC_FLUSH
  } exec_state_type;

  exec_state_type state;
  exec_state_type next_state;

  // Every decode shares one accept term, so a dropped slot is dropped
  // for all operations alike
  function automatic logic op_taken
  (
    input logic accept,
    input exec_pkg::op_type op,
    input exec_pkg::op_type want
  );
    return accept && op == want;
  endfunction

  function automatic logic [exec_pkg::PC_W-1:0] pc_step
  (
    input logic [exec_pkg::PC_W-1:0] pc
  );
    return pc + 13'h0001;
  endfunction

  wire flush_cycle = state == EXEC_FLUSH;
  wire take = instr_valid && instr_ready;
  wire is_copy = op_taken(take, instr_op, exec_pkg::OP_COPY_REGISTER);
  wire is_lit = op_taken(take, instr_op, exec_pkg::OP_LOAD_LITERAL);
  wire is_store = op_taken(take, instr_op, exec_pkg::OP_STORE_ACCUMULATOR);
  wire is_retlit =
    op_taken(take, instr_op, exec_pkg::OP_RETURN_WITH_LITERAL);
  wire is_retint =
    op_taken(take, instr_op, exec_pkg::OP_RETURN_FROM_INTERRUPT);
  wire is_rot = op_taken(take, instr_op, exec_pkg::OP_ROTATE_LEFT);
  wire is_call = op_taken(take, instr_op, exec_pkg::OP_CALL);
  wire is_pop = is_retlit || is_retint;

  // Nine-bit ring: carry into bit 0, bit 7 out to carry
  wire [exec_pkg::DATA_W-1:0] rot_value =
    {reg_rdata[exec_pkg::DATA_W-2:0], rotate_out_bit};

  wire [exec_pkg::DATA_W-1:0] op_result = is_rot ? rot_value : reg_rdata;
  wire to_reg = (is_copy || is_rot) &&
    result_target_select == exec_pkg::TARGET_REG;
  wire to_acc_from_reg = (is_copy || is_rot) &&
    result_target_select == exec_pkg::TARGET_ACC;

  ////////////////////////////////////////////////////////////////////////
  // Return stack

  return_stack_if stack_bus();

  return_stack u_stack
  (
    .mclk(mclk),
    .reset_n(core_reset_n),
    .port_s(stack_bus)
  );

  // Push and pop never coincide: call and the returns are distinct ops
  assign stack_bus.push = is_call;
  assign stack_bus.pop = is_pop;
  assign stack_bus.push_addr = pc_step(program_counter);

  ////////////////////////////////////////////////////////////////////////
  // Register file port

  // Register file is read combinationally at the operand index
  assign reg_addr = operand_register_index;
  assign reg_we = to_reg || is_store;
  assign reg_wdata = is_store ? accumulator : op_result;

  // Flushed fetch slot occupies the second cycle of a return
  assign flush = flush_cycle;
  assign instr_ready = core_reset_n && !flush_cycle;

  ////////////////////////////////////////////////////////////////////////
  // Next values

  wire [exec_pkg::PC_W-1:0] next_program_counter =
    is_pop ? stack_bus.top_of_stack :
    is_call ? call_target :
    take ? pc_step(program_counter) :
    program_counter;

  wire [exec_pkg::DATA_W-1:0] next_accumulator =
    (is_lit || is_retlit) ? literal_value :
    to_acc_from_reg ? op_result :
    accumulator;

  // Only copy touches the null flag; literal, store, return leave it
  wire next_result_null_flag =
    is_copy ? (reg_rdata == 8'h00) : result_null_flag;
  wire next_rotate_out_bit =
    is_rot ? reg_rdata[exec_pkg::DATA_W-1] : rotate_out_bit;
  wire next_master_interrupt_enable =
    is_retint ? 1'h1 : master_interrupt_enable;

  always_comb
  begin
    next_state = state;
    case (state)
      EXEC_RUN:
        if (is_pop)
          next_state = EXEC_FLUSH;
      EXEC_FLUSH:
        next_state = EXEC_RUN;
      default:
        next_state = EXEC_RUN;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // State

  always_ff @(posedge mclk or negedge core_reset_n)
  begin
    if (!core_reset_n)
      state <= EXEC_RUN;
    else
      state <= next_state;
  end

  always_ff @(posedge mclk or negedge core_reset_n)
  begin
    if (!core_reset_n)
      program_counter <= exec_pkg::PC_RESET;
    else
      program_counter <= next_program_counter;
  end

  always_ff @(posedge mclk or negedge core_reset_n)
  begin
    if (!core_reset_n)
      accumulator <= exec_pkg::ACC_RESET;
    else
      accumulator <= next_accumulator;
  end

  always_ff @(posedge mclk or negedge core_reset_n)
  begin
    if (!core_reset_n)
      result_null_flag <= 1'h0;
    else
      result_null_flag <= next_result_null_flag;
  end

  always_ff @(posedge mclk or negedge core_reset_n)
  begin
    if (!core_reset_n)
      rotate_out_bit <= 1'h0;
    else
      rotate_out_bit <= next_rotate_out_bit;
  end

  always_ff @(posedge mclk or negedge core_reset_n)
  begin
    if (!core_reset_n)
      master_interrupt_enable <= 1'h0;
    else
      master_interrupt_enable <= next_master_interrupt_enable;
  end

endmodule // move_return_rotate_exec

`default_nettype wire

// ---- tb/exec_props.sv ----
`timescale 1ns/1ps
`default_nettype none
module exec_props
(
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic instr_valid,
  input wire logic instr_ready,
  input wire logic flush,
  input wire logic result_target_select,
  input wire logic reg_we,
  input wire logic result_null_flag,
  input wire logic rotate_out_bit,
  input wire logic master_interrupt_enable,
  input wire exec_pkg::op_type instr_op,
  input wire logic [7:0] literal_value,
  input wire logic [7:0] reg_rdata,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] accumulator
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  wire t = instr_valid && instr_ready;
  wire d = result_target_select;
  wire ld = t && instr_op == exec_pkg::OP_LOAD_LITERAL;
  wire st = t && instr_op == exec_pkg::OP_STORE_ACCUMULATOR;
  wire cp = t && instr_op == exec_pkg::OP_COPY_REGISTER;
  wire rt = t && instr_op == exec_pkg::OP_ROTATE_LEFT;
  wire rl = t && instr_op == exec_pkg::OP_RETURN_WITH_LITERAL;
  wire rf = t && instr_op == exec_pkg::OP_RETURN_FROM_INTERRUPT;
  wire [8:0] ring = {reg_rdata, rotate_out_bit};
  lit_load_a: assert property (ld |=> accumulator ==
    $past(literal_value) && $stable(result_null_flag)) else $error("load");
  store_acc_a: assert property (st |-> reg_we &&
    reg_wdata == accumulator) else $error("store");
  copy_null_a: assert property (cp |=>
    result_null_flag == ($past(reg_rdata) == 8'h00)) else $error("null");
  copy_acc_a: assert property (cp && !d |=>
    accumulator == $past(reg_rdata)) else $error("copy");
  rot_acc_a: assert property (rt && !d |=>
    {rotate_out_bit, accumulator} == $past(ring)) else $error("rot");
  rot_reg_a: assert property (rt && d |-> reg_we &&
    reg_wdata == ring[7:0]) else $error("rot reg");
  ret_lit_a: assert property (rl |=> flush &&
    accumulator == $past(literal_value)) else $error("ret lit");
  flush_len_a: assert property (flush |->
    !instr_ready ##1 !flush) else $error("flush");
  ret_int_a: assert property (rf |=>
    master_interrupt_enable && flush) else $error("ret int");
  cover property (rl);
  cover property (rt && d);
  cover property (cp && d);
endmodule // exec_props
bind move_return_rotate_exec exec_props props
(
  .mclk(mclk),
  .reset_n(reset_n),
  .instr_valid(instr_valid),
  .instr_ready(instr_ready),
  .flush(flush),
  .result_target_select(result_target_select),
  .reg_we(reg_we),
  .result_null_flag(result_null_flag),
  .rotate_out_bit(rotate_out_bit),
  .master_interrupt_enable(master_interrupt_enable),
  .instr_op(instr_op),
  .literal_value(literal_value),
  .reg_rdata(reg_rdata),
  .reg_wdata(reg_wdata),
  .accumulator(accumulator)
);
`default_nettype wire

// ---- tb/reg_file_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module reg_file_model
(
  input wire logic mclk,
  input wire logic reg_we,
  input wire logic [6:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata
);
  logic [7:0] mem [128];
  // Unwritten entries read unknown on purpose
  assign reg_rdata = mem[reg_addr];
  always_ff @(posedge mclk)
    if (reg_we) mem[reg_addr] <= reg_wdata;
endmodule // reg_file_model
`default_nettype wire

// ---- tb/tb_move_return_rotate_exec.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_move_return_rotate_exec;
  logic mclk = 1'h0, reset_n = 1'h0, instr_valid = 1'h0;
  logic result_target_select = 1'h0, master_interrupt_enable;
  exec_pkg::op_type instr_op = exec_pkg::OP_NOP;
  logic [6:0] operand_register_index = 7'h00, reg_addr;
  logic [7:0] literal_value = 8'h00, reg_wdata, reg_rdata, accumulator;
  logic [12:0] call_target = 13'h1ABC, program_counter;
  logic reg_we, result_null_flag, rotate_out_bit, flush, instr_ready;
  int err_total = 0, comparisons = 0;
  always #20 mclk = ~mclk;
  move_return_rotate_exec dut
  (
    .mclk(mclk),
    .reset_n(reset_n),
    .instr_valid(instr_valid),
    .instr_op(instr_op),
    .operand_register_index(operand_register_index),
    .result_target_select(result_target_select),
    .literal_value(literal_value),
    .call_target(call_target),
    .reg_rdata(reg_rdata),
    .reg_addr(reg_addr),
    .reg_we(reg_we),
    .reg_wdata(reg_wdata),
    .program_counter(program_counter),
    .accumulator(accumulator),
    .result_null_flag(result_null_flag),
    .rotate_out_bit(rotate_out_bit),
    .master_interrupt_enable(master_interrupt_enable),
    .flush(flush),
    .instr_ready(instr_ready)
  );
  reg_file_model rf
  (
    .mclk(mclk),
    .reg_we(reg_we),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata)
  );
  task automatic chk(string n, logic [12:0] s, e);
    comparisons++;
    if (s !== e)
    begin
      err_total++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic ex(exec_pkg::op_type o, logic [6:0] a, logic d,
    logic [7:0] k);
    instr_op = o;
    operand_register_index = a;
    result_target_select = d;
    literal_value = k;
    instr_valid = 1'h1;
    @(negedge mclk);
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic test_moves;
    ex(exec_pkg::OP_LOAD_LITERAL, 7'h00, 1'h0, 8'h81);
    ex(exec_pkg::OP_STORE_ACCUMULATOR, 7'h7F, 1'h0, 8'h00);
    chk("we", reg_we, 1'h1);
    chk("wdata", reg_wdata, 8'h81);
    ex(exec_pkg::OP_LOAD_LITERAL, 7'h00, 1'h0, 8'h00);
    ex(exec_pkg::OP_STORE_ACCUMULATOR, 7'h00, 1'h0, 8'h00);
    ex(exec_pkg::OP_COPY_REGISTER, 7'h7F, 1'h0, 8'h00);
    chk("null", result_null_flag, 1'h0);
    chk("addr", reg_addr, 7'h7F);
    ex(exec_pkg::OP_COPY_REGISTER, 7'h00, 1'h1, 8'h00);
    chk("acc", accumulator, 8'h81);
    chk("null", result_null_flag, 1'h1);
    ex(exec_pkg::OP_NOP, 7'h00, 1'h0, 8'h00);
    chk("pc", program_counter, 13'h0007);
    chk("acc", accumulator, 8'h81);
    $display("moves done");
  endtask
  task automatic test_rotate;
    ex(exec_pkg::OP_ROTATE_LEFT, 7'h7F, 1'h0, 8'h00);
    chk("acc", accumulator, 8'h02);
    chk("carry", rotate_out_bit, 1'h1);
    ex(exec_pkg::OP_ROTATE_LEFT, 7'h7F, 1'h1, 8'h00);
    chk("null", result_null_flag, 1'h1);
    ex(exec_pkg::OP_COPY_REGISTER, 7'h7F, 1'h0, 8'h00);
    chk("acc", accumulator, 8'h03);
    $display("rotate done");
  endtask
  task automatic test_returns;
    ex(exec_pkg::OP_CALL, 7'h00, 1'h0, 8'h00);
    instr_valid = 1'h0;
    @(negedge mclk);
    ex(exec_pkg::OP_RETURN_WITH_LITERAL, 7'h00, 1'h0, 8'h5A);
    chk("acc", accumulator, 8'h5A);
    chk("pc", program_counter, 13'h000B);
    chk("ready", instr_ready, 1'h0);
    chk("flush", flush, 1'h1);
    // Presented during the flush slot, must be dropped
    ex(exec_pkg::OP_LOAD_LITERAL, 7'h00, 1'h0, 8'hFF);
    chk("acc", accumulator, 8'h5A);
    chk("pc", program_counter, 13'h000B);
    chk("flush", flush, 1'h0);
    ex(exec_pkg::OP_CALL, 7'h00, 1'h0, 8'h00);
    instr_valid = 1'h0;
    @(negedge mclk);
    chk("mie", master_interrupt_enable, 1'h0);
    ex(exec_pkg::OP_RETURN_FROM_INTERRUPT, 7'h00, 1'h0, 8'h00);
    chk("mie", master_interrupt_enable, 1'h1);
    chk("pc", program_counter, 13'h000C);
    instr_valid = 1'h0;
    @(negedge mclk);
    $display("returns done");
  endtask
  initial
  begin
    repeat (10) @(negedge mclk);
    reset_n = 1'h1;
    // Core leaves reset two edges after the pin
    repeat (2) @(negedge mclk);
    test_moves();
    test_rotate();
    test_returns();
    end_sim();
  end
  initial
  begin
    #20us;
    err_total++;
    end_sim();
  end
endmodule // tb_move_return_rotate_exec
`default_nettype wire
